// ===== core/cfgpm_mirror.sv
// Configuration register mirrors and received access report.
// Assumes accesses arrive one per cycle, already checked as valid.
`timescale 1ns/100ps
`default_nettype none

module cfgpm_mirror (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Received configuration access
  input wire logic acc_valid,
  input wire logic [9:0] acc_dword,
  input wire logic acc_write,
  input wire logic [31:0] acc_data,
  input wire logic [3:0] acc_be,
  // Access report and mirrors
  output cfgpm_pkg::cfgpm_acc_t report,
  output cfgpm_pkg::cfgpm_mirror_t mirror
);

  logic [15:0] cmd_r;
  logic [15:0] devctl_r;
  logic [4:0] devctl2_r;
  cfgpm_pkg::cfgpm_acc_t report_r;

  // Byte-lane merge of a 16-bit field; used for every mirrored register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
      input logic [15:0] wd, input logic [1:0] be);
    lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Decode of the access
  wire in_range_w = acc_dword < cfgpm_pkg::CFG_REPORT_LIMIT;
  wire cfg_wr_w = acc_valid && acc_write;
  wire cmd_wr_w = cfg_wr_w && acc_dword == cfgpm_pkg::CMD_DW;
  wire dc_wr_w = cfg_wr_w && acc_dword == cfgpm_pkg::DEVCTL_DW;
  wire dc2_wr_w = cfg_wr_w && acc_dword == cfgpm_pkg::DEVCTL2_DW;
  wire [15:0] dc2_new_w = lane_merge({11'h000, devctl2_r},
      acc_data[15:0], acc_be[1:0]);

  // Mirror registers, updated at the edge that takes the write
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_r <= cfgpm_pkg::CMD_RST;
      devctl_r <= cfgpm_pkg::DEVCTL_RST;
      devctl2_r <= cfgpm_pkg::DEVCTL2_RST;
    end else begin
      if (cmd_wr_w) cmd_r <= lane_merge(cmd_r, acc_data[15:0], acc_be[1:0]);
      if (dc_wr_w) devctl_r <= lane_merge(devctl_r, acc_data[15:0],
          acc_be[1:0]);
      if (dc2_wr_w) devctl2_r <= dc2_new_w[4:0];
    end
  end

  // Access report; offset and type are loaded every cycle, valid only with the pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      report_r <= '0;
    end else begin
      report_r.pulse <= acc_valid && in_range_w;
      report_r.offset <= acc_dword[6:0];
      report_r.is_write <= acc_write;
    end
  end

  // Field extraction straight from the registers
  assign report = report_r;
  assign mirror.io_on = cmd_r[cfgpm_pkg::CMD_IO_BIT];
  assign mirror.mem_on = cmd_r[cfgpm_pkg::CMD_MEM_BIT];
  assign mirror.bme = cmd_r[cfgpm_pkg::CMD_BME_BIT];
  assign mirror.serr = cmd_r[cfgpm_pkg::CMD_SERR_BIT];
  assign mirror.intd = cmd_r[cfgpm_pkg::CMD_INTD_BIT];
  assign mirror.cto_dis = devctl2_r[cfgpm_pkg::DC2_CTO_DIS_BIT];
  assign mirror.cto = devctl2_r[cfgpm_pkg::DC2_CTO_LSB +: 4];
  assign mirror.corr_on = devctl_r[cfgpm_pkg::DC_CORR_BIT];
  assign mirror.fatal_on = devctl_r[cfgpm_pkg::DC_FATAL_BIT];
  assign mirror.ro = devctl_r[cfgpm_pkg::DC_RO_BIT];
  assign mirror.ext_tag = devctl_r[cfgpm_pkg::DC_EXTTAG_BIT];
  assign mirror.mps = devctl_r[cfgpm_pkg::DC_MPS_LSB +: 3];
  assign mirror.mrrs = devctl_r[cfgpm_pkg::DC_MRRS_LSB +: 3];

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  acc_report_a: assert property (acc_valid && in_range_w |=> report.pulse
      && report.offset == $past(acc_dword[6:0])
      && report.is_write == $past(acc_write))
    else $error("access report wrong after in-range access");
  acc_range_a: assert property (!(acc_valid && in_range_w) |=>
      !report.pulse)
    else $error("access pulse without in-range access");
  mirror_follow_a: assert property (cmd_wr_w && acc_be[0] |=>
      mirror.bme == $past(acc_data[2]) && mirror.io_on == $past(acc_data[0]))
    else $error("command mirror did not follow write");

endmodule

`default_nettype wire

// ===== core/cfgpm_pkg.sv
// Constants and carrier types for the configuration sideband block.
// Assumes one user clock, a synchronous reset and APB register access.
`default_nettype none

package cfgpm_pkg;

  // --------------------------------------------------------------------
  // APB register map
  // --------------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_MIRROR = 12'h008;
  localparam int CTRL_ROOT_BIT = 0;
  localparam logic CTRL_ROOT_RST = 1'b0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ASPM_ARM_BIT = 2;
  localparam int STAT_OFFOK_ARM_BIT = 3;
  localparam int STAT_DIRECT_L1_BIT = 4;

  // --------------------------------------------------------------------
  // Configuration space layout
  // --------------------------------------------------------------------
  localparam logic [9:0] CFG_REPORT_LIMIT = 10'h080;
  localparam logic [9:0] CMD_DW = 10'h001;
  localparam logic [9:0] DEVCTL_DW = 10'h01A;
  localparam logic [9:0] DEVCTL2_DW = 10'h022;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] DEVCTL_RST = 16'h0000;
  localparam logic [4:0] DEVCTL2_RST = 5'h00;
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_BME_BIT = 2;
  localparam int CMD_SERR_BIT = 8;
  localparam int CMD_INTD_BIT = 10;
  localparam int DC_CORR_BIT = 0;
  localparam int DC_FATAL_BIT = 2;
  localparam int DC_RO_BIT = 4;
  localparam int DC_MPS_LSB = 5;
  localparam int DC_EXTTAG_BIT = 8;
  localparam int DC_MRRS_LSB = 12;
  localparam int DC2_CTO_LSB = 0;
  localparam int DC2_CTO_DIS_BIT = 4;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    TO_IDLE, TO_WAIT_ACK, TO_WAIT_L23, TO_L3
  } cfgpm_to_state_t;

  typedef struct packed {
    logic io_on, mem_on, bme, serr, intd, cto_dis;
    logic [3:0] cto;
    logic corr_on, fatal_on, ro, ext_tag;
    logic [2:0] mps, mrrs;
  } cfgpm_mirror_t;

  typedef struct packed {
    logic pulse;
    logic [6:0] offset;
    logic is_write;
  } cfgpm_acc_t;

  typedef struct packed {
    logic aspm_seen_n, l23_seen_n, ack_seen_n, to_seen, to_ack_seen;
    logic [15:0] msg_data;
    logic l3_ready;
  } cfgpm_pm_t;

  typedef struct packed {
    logic pm_req_ack, as_nak, turn_off, turn_off_ack, pme;
    logic err_cor, err_nonfatal, err_fatal, intx, ur, accept;
  } cfgpm_tx_t;

  localparam cfgpm_pm_t PM_RST = '{aspm_seen_n: 1'b1, l23_seen_n: 1'b1,
    ack_seen_n: 1'b1, to_seen: 1'b0, to_ack_seen: 1'b0,
    msg_data: 16'h0000, l3_ready: 1'b0};

endpackage

`default_nettype wire

// ===== core/cfgpm_top.sv
// Power management sideband, access report and mirrors of the config block.
// Assumes link events arrive as one-cycle pulses in the user clock domain.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module cfgpm_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Link receive events
  input wire logic RX_ENTER_L1,
  input wire logic RX_ENTER_L23,
  input wire logic RX_AS_REQ_L1,
  input wire logic RX_REQ_ACK,
  input wire logic RX_TURN_OFF,
  input wire logic RX_TURN_OFF_ACK,
  input wire logic [15:0] RX_MSG_RID,
  input wire logic RX_IO_REQ,
  input wire logic RX_MEM_REQ,
  // Received configuration accesses
  input wire logic RX_CFG_VALID,
  input wire logic [9:0] RX_CFG_DWORD,
  input wire logic RX_CFG_WRITE,
  input wire logic [31:0] RX_CFG_DATA,
  input wire logic [3:0] RX_CFG_BE,
  // Internal error events and interrupt request
  input wire logic ERR_COR,
  input wire logic ERR_NONFATAL,
  input wire logic ERR_FATAL,
  input wire logic FWD_NONFATAL,
  input wire logic FWD_FATAL,
  input wire logic INTX_REQ,
  // User power management inputs
  input wire logic DIRECT_ASPM_L1_REQ_N,
  input wire logic PM_ACK_SEND_N,
  input wire logic PM_NAK_SEND_N,
  input wire logic TURN_OFF_SEND_N,
  input wire logic POWER_OFF_SAFE_N,
  input wire logic WAKE_REQUEST_N,
  // User power management outputs
  output logic ASPM_L1_REQUEST_SEEN_N,
  output logic L23_ENTRY_SEEN_N,
  output logic PM_ACK_SEEN_N,
  output logic TURN_OFF_MSG_SEEN,
  output logic TURN_OFF_ACK_SEEN,
  output logic [15:0] MSG_DATA,
  output logic L3_READY,
  // Configuration access report
  output logic CFG_ACCESS_PULSE,
  output logic [6:0] CFG_ACCESS_DWORD_OFFSET,
  output logic CFG_ACCESS_IS_WRITE,
  // Register mirrors
  output logic BUS_MASTER_ALLOWED,
  output logic LEGACY_IRQ_BLOCKED,
  output logic IO_SPACE_ALLOWED,
  output logic MEM_SPACE_ALLOWED,
  output logic SYSTEM_ERROR_ALLOWED,
  output logic CPL_TIMEOUT_OFF,
  output logic [3:0] CPL_TIMEOUT_RANGE,
  output logic CORR_ERR_REPORT_ON,
  output logic FATAL_ERR_REPORT_ON,
  output logic RELAXED_ORDER_ALLOWED,
  output logic WIDE_TAG_ALLOWED,
  output logic [2:0] PAYLOAD_LIMIT,
  output logic [2:0] READ_REQUEST_LIMIT,
  // Link transmit requests
  output logic TX_PM_REQ_ACK,
  output logic TX_AS_NAK,
  output logic TX_TURN_OFF,
  output logic TX_TURN_OFF_ACK,
  output logic TX_PME,
  output logic TX_ERR_COR,
  output logic TX_ERR_NONFATAL,
  output logic TX_ERR_FATAL,
  output logic TX_INTX,
  output logic TX_UR,
  output logic RX_REQ_ACCEPT
);

  logic root_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_data_w;
  logic rd_hit_w;
  logic aspm_arm_r;
  logic offok_arm_r;
  logic to_hi_r;
  logic wake_hi_r;
  cfgpm_pkg::cfgpm_to_state_t to_state_r, to_state_nxt;
  cfgpm_pkg::cfgpm_pm_t pm_r, pm_nxt;
  cfgpm_pkg::cfgpm_tx_t tx_r, tx_nxt;
  cfgpm_pkg::cfgpm_acc_t report_w;
  cfgpm_pkg::cfgpm_mirror_t mirror_w;

  // --------------------------------------------------------------------
  // Mirrors and access report
  // --------------------------------------------------------------------
  cfgpm_mirror u_mirror (
    .clk(MCLK),
    .rst(SYS_RST),
    .acc_valid(RX_CFG_VALID),
    .acc_dword(RX_CFG_DWORD),
    .acc_write(RX_CFG_WRITE),
    .acc_data(RX_CFG_DATA),
    .acc_be(RX_CFG_BE),
    .report(report_w),
    .mirror(mirror_w)
  );

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // Every access takes one wait-free access phase: ready is the setup echo
  wire setup_w = PSEL && !PENABLE;
  wire access_w = PSEL && PENABLE && pready_r;
  wire ctrl_wr_w = access_w && PWRITE && PSTRB[0]
      && PADDR == cfgpm_pkg::OFF_CTRL;

  // Read decode; unmapped addresses read zero and flag an error
  always_comb begin
    rd_data_w = '0;
    rd_hit_w = 1'b1;
    if (PADDR == cfgpm_pkg::OFF_CTRL) begin
      rd_data_w[cfgpm_pkg::CTRL_ROOT_BIT] = root_r;
    end else if (PADDR == cfgpm_pkg::OFF_STAT) begin
      rd_data_w[cfgpm_pkg::STAT_STATE_LSB +: 2] = to_state_r;
      rd_data_w[cfgpm_pkg::STAT_ASPM_ARM_BIT] = aspm_arm_r;
      rd_data_w[cfgpm_pkg::STAT_OFFOK_ARM_BIT] = offok_arm_r;
      rd_data_w[cfgpm_pkg::STAT_DIRECT_L1_BIT] = DIRECT_ASPM_L1_REQ_N;
    end else if (PADDR == cfgpm_pkg::OFF_MIRROR) begin
      rd_data_w[$bits(mirror_w)-1:0] = mirror_w;
    end else begin
      rd_hit_w = 1'b0;
    end
  end

  // Answer is loaded at the setup edge and held through the access phase
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup_w;
      if (setup_w) begin
        pslverr_r <= !rd_hit_w;
        prdata_r <= PWRITE ? 32'h00000000 : rd_data_w;
      end
    end
  end

  // Port mode; a change drops any armed handshake
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      root_r <= cfgpm_pkg::CTRL_ROOT_RST;
    end else if (ctrl_wr_w) begin
      root_r <= PWDATA[cfgpm_pkg::CTRL_ROOT_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Power management handshakes
  // --------------------------------------------------------------------
  wire ep_w = !root_r;
  wire aspm_req_w = root_r && RX_AS_REQ_L1;
  wire nak_go_w = root_r && aspm_arm_r && !PM_NAK_SEND_N;
  wire ack_go_w = root_r && aspm_arm_r && !PM_ACK_SEND_N
      && PM_NAK_SEND_N;
  wire auto_ack_w = root_r && (RX_ENTER_L1 || RX_ENTER_L23);
  // Edge detect so a held turn-off input sends one message only
  wire to_go_w = root_r && !TURN_OFF_SEND_N && to_hi_r;
  wire off_ok_w = offok_arm_r && !POWER_OFF_SAFE_N;
  wire wake_go_w = !WAKE_REQUEST_N && wake_hi_r;

  // Armed flags; a new arming event wins over a clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      aspm_arm_r <= 1'b0;
      offok_arm_r <= 1'b0;
      to_hi_r <= 1'b1;
      wake_hi_r <= 1'b1;
    end else begin
      if (aspm_req_w) aspm_arm_r <= 1'b1;
      else if (ack_go_w || nak_go_w || ep_w) aspm_arm_r <= 1'b0;
      if (ep_w && RX_TURN_OFF) offok_arm_r <= 1'b1;
      else if (off_ok_w || root_r) offok_arm_r <= 1'b0;
      to_hi_r <= TURN_OFF_SEND_N;
      wake_hi_r <= WAKE_REQUEST_N;
    end
  end

  // Root Port turn-off sequence toward L3 ready
  always_comb begin
    to_state_nxt = to_state_r;
    case (to_state_r)
      cfgpm_pkg::TO_IDLE, cfgpm_pkg::TO_L3: begin
        if (to_go_w) to_state_nxt = cfgpm_pkg::TO_WAIT_ACK;
      end
      cfgpm_pkg::TO_WAIT_ACK: begin
        if (RX_ENTER_L23) to_state_nxt = cfgpm_pkg::TO_L3;
        else if (RX_TURN_OFF_ACK) to_state_nxt = cfgpm_pkg::TO_WAIT_L23;
      end
      cfgpm_pkg::TO_WAIT_L23: begin
        if (RX_ENTER_L23) to_state_nxt = cfgpm_pkg::TO_L3;
      end
      default: to_state_nxt = cfgpm_pkg::TO_IDLE;
    endcase
    if (ep_w) to_state_nxt = cfgpm_pkg::TO_IDLE;
  end

  // Status toward user logic; active-low outputs idle high
  always_comb begin
    pm_nxt.aspm_seen_n = !aspm_req_w;
    pm_nxt.l23_seen_n = !(root_r && RX_ENTER_L23);
    pm_nxt.ack_seen_n = !(ep_w && RX_REQ_ACK);
    pm_nxt.to_seen = ep_w && RX_TURN_OFF;
    pm_nxt.to_ack_seen = root_r && RX_TURN_OFF_ACK;
    pm_nxt.msg_data = (RX_TURN_OFF || RX_TURN_OFF_ACK) ? RX_MSG_RID
        : pm_r.msg_data;
    pm_nxt.l3_ready = to_state_nxt == cfgpm_pkg::TO_L3;
  end

  // Transmit requests; error gating keeps Root Port reports internal
  always_comb begin
    tx_nxt.pm_req_ack = ack_go_w || auto_ack_w;
    tx_nxt.as_nak = nak_go_w;
    tx_nxt.turn_off = to_go_w;
    tx_nxt.turn_off_ack = off_ok_w;
    tx_nxt.pme = wake_go_w;
    tx_nxt.err_cor = ep_w && ERR_COR && mirror_w.corr_on;
    tx_nxt.err_nonfatal = mirror_w.serr
        && (ep_w ? ERR_NONFATAL : FWD_NONFATAL);
    tx_nxt.err_fatal = ep_w ? ERR_FATAL && (mirror_w.serr
        || mirror_w.fatal_on) : FWD_FATAL && mirror_w.serr;
    tx_nxt.intx = INTX_REQ && !mirror_w.intd;
    tx_nxt.ur = ep_w && ((RX_IO_REQ && !mirror_w.io_on)
        || (RX_MEM_REQ && !mirror_w.mem_on));
    tx_nxt.accept = (RX_IO_REQ && (root_r || mirror_w.io_on))
        || (RX_MEM_REQ && (root_r || mirror_w.mem_on));
  end

  // Output registers
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      to_state_r <= cfgpm_pkg::TO_IDLE;
      pm_r <= cfgpm_pkg::PM_RST;
      tx_r <= '0;
    end else begin
      to_state_r <= to_state_nxt;
      pm_r <= pm_nxt;
      tx_r <= tx_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Port mapping
  // --------------------------------------------------------------------
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign ASPM_L1_REQUEST_SEEN_N = pm_r.aspm_seen_n;
  assign L23_ENTRY_SEEN_N = pm_r.l23_seen_n;
  assign PM_ACK_SEEN_N = pm_r.ack_seen_n;
  assign TURN_OFF_MSG_SEEN = pm_r.to_seen;
  assign TURN_OFF_ACK_SEEN = pm_r.to_ack_seen;
  assign MSG_DATA = pm_r.msg_data;
  assign L3_READY = pm_r.l3_ready;
  assign CFG_ACCESS_PULSE = report_w.pulse;
  assign CFG_ACCESS_DWORD_OFFSET = report_w.offset;
  assign CFG_ACCESS_IS_WRITE = report_w.is_write;
  assign BUS_MASTER_ALLOWED = mirror_w.bme;
  assign LEGACY_IRQ_BLOCKED = mirror_w.intd;
  assign IO_SPACE_ALLOWED = mirror_w.io_on;
  assign MEM_SPACE_ALLOWED = mirror_w.mem_on;
  assign SYSTEM_ERROR_ALLOWED = mirror_w.serr;
  assign CPL_TIMEOUT_OFF = mirror_w.cto_dis;
  assign CPL_TIMEOUT_RANGE = mirror_w.cto;
  assign CORR_ERR_REPORT_ON = mirror_w.corr_on;
  assign FATAL_ERR_REPORT_ON = mirror_w.fatal_on;
  assign RELAXED_ORDER_ALLOWED = mirror_w.ro;
  assign WIDE_TAG_ALLOWED = mirror_w.ext_tag;
  assign PAYLOAD_LIMIT = mirror_w.mps;
  assign READ_REQUEST_LIMIT = mirror_w.mrrs;
  assign TX_PM_REQ_ACK = tx_r.pm_req_ack;
  assign TX_AS_NAK = tx_r.as_nak;
  assign TX_TURN_OFF = tx_r.turn_off;
  assign TX_TURN_OFF_ACK = tx_r.turn_off_ack;
  assign TX_PME = tx_r.pme;
  assign TX_ERR_COR = tx_r.err_cor;
  assign TX_ERR_NONFATAL = tx_r.err_nonfatal;
  assign TX_ERR_FATAL = tx_r.err_fatal;
  assign TX_INTX = tx_r.intx;
  assign TX_UR = tx_r.ur;
  assign RX_REQ_ACCEPT = tx_r.accept;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence aspm_req_s;
    root_r && RX_AS_REQ_L1 ##1 PM_ACK_SEND_N && PM_NAK_SEND_N;
  endsequence
  sequence user_ack_s;
    root_r && !PM_ACK_SEND_N && PM_NAK_SEND_N;
  endsequence
  sequence user_both_s;
    root_r && !PM_ACK_SEND_N && !PM_NAK_SEND_N;
  endsequence

  l23_pulse_a: assert property (root_r && RX_ENTER_L23 |=>
      !L23_ENTRY_SEEN_N && TX_PM_REQ_ACK ##1
      (L23_ENTRY_SEEN_N || $past(RX_ENTER_L23)))
    else $error("L23 entry not reported as one pulse");
  req_ack_a: assert property (ep_w && RX_REQ_ACK |=> !PM_ACK_SEEN_N)
    else $error("request ack not reported");
  aspm_ack_a: assert property (aspm_req_s ##1 user_ack_s |=>
      TX_PM_REQ_ACK && !TX_AS_NAK)
    else $error("user ack did not send request ack");
  nak_wins_a: assert property (aspm_req_s ##1 user_both_s |=>
      TX_AS_NAK && !aspm_arm_r)
    else $error("nak did not win over ack");
  auto_ack_a: assert property (root_r && RX_ENTER_L1 |=>
      TX_PM_REQ_ACK)
    else $error("software L1 entry not acknowledged");
  turn_off_a: assert property (root_r && $fell(TURN_OFF_SEND_N) |=>
      TX_TURN_OFF ##1 !TX_TURN_OFF)
    else $error("turn-off request not sent once");
  wake_pme_a: assert property ($fell(WAKE_REQUEST_N) |=> TX_PME)
    else $error("wake did not send PME");
  intx_block_a: assert property (LEGACY_IRQ_BLOCKED |=> !TX_INTX)
    else $error("INTx sent while disabled");
  space_ur_a: assert property (ep_w && RX_MEM_REQ && !MEM_SPACE_ALLOWED
      |=> TX_UR && !RX_REQ_ACCEPT)
    else $error("disabled memory access not refused");
  serr_gate_a: assert property (!SYSTEM_ERROR_ALLOWED |=>
      !TX_ERR_NONFATAL)
    else $error("non-fatal report without system error enable");
  root_cor_a: assert property (root_r |=> !TX_ERR_COR)
    else $error("Root Port sent correctable message");
  turn_off_rx_a: assert property (ep_w && RX_TURN_OFF |=>
      TURN_OFF_MSG_SEEN && MSG_DATA == $past(RX_MSG_RID))
    else $error("turn-off message not reported");

endmodule

`default_nettype wire

// ===== sim/cfgpm_top_tb.sv
// Bench for the sideband block: a table of config accesses, then PM cases.
// Assumes the user model answers the power management handshakes.
`timescale 1ns/100ps
`default_nettype none
module cfgpm_top_tb;
  logic MCLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, NAK_MODE = 1'b0, INTX_REQ = 1'b0, RX_CFG_WRITE = 1'b0;
  logic DIRECT_ASPM_L1_REQ_N = 1'b1, err;
  logic [3:0] PSTRB = 4'hF, RX_CFG_BE = 4'hF;
  logic [9:0] RX_CFG_DWORD = 10'h000;
  logic [11:0] PADDR = 12'h000;
  logic [15:0] ev = 16'h0000, RX_MSG_RID = 16'h0000;
  logic [31:0] PWDATA = 32'h0, RX_CFG_DATA = 32'h0, rd;
  int bad_count = 0, n_checks = 0;
  // Rows: dword, write flag, data; the pulse is expected below dword 80h
  logic [42:0] rows [5] = '{{10'h001, 1'b1, 32'h507}, {10'h07F, 1'b0, 32'h0},
    {10'h080, 1'b1, 32'h0}, {10'h01A, 1'b1, 32'h5171}, {10'h022, 1'b1, 32'h1E}};
  // Event inputs share one vector so one task can pulse any set of them
  wire RX_ENTER_L1 = ev[0], RX_ENTER_L23 = ev[1], RX_AS_REQ_L1 = ev[2];
  wire RX_REQ_ACK = ev[3], RX_TURN_OFF = ev[4], RX_TURN_OFF_ACK = ev[5];
  wire RX_IO_REQ = ev[6], RX_MEM_REQ = ev[7], ERR_COR = ev[8];
  wire ERR_NONFATAL = ev[9], ERR_FATAL = ev[10], FWD_NONFATAL = ev[11];
  wire FWD_FATAL = ev[12], RX_CFG_VALID = ev[13];
  wire WAKE_REQUEST_N = !ev[14], TURN_OFF_SEND_N = !ev[15];
  wire PM_ACK_SEND_N, PM_NAK_SEND_N, POWER_OFF_SAFE_N, PREADY, PSLVERR, TX_UR;
  wire ASPM_L1_REQUEST_SEEN_N, L23_ENTRY_SEEN_N, PM_ACK_SEEN_N, L3_READY;
  wire TURN_OFF_MSG_SEEN, TURN_OFF_ACK_SEEN, CFG_ACCESS_PULSE, TX_INTX;
  wire CFG_ACCESS_IS_WRITE, BUS_MASTER_ALLOWED, LEGACY_IRQ_BLOCKED, TX_PME;
  wire IO_SPACE_ALLOWED, MEM_SPACE_ALLOWED, SYSTEM_ERROR_ALLOWED, TX_AS_NAK;
  wire CPL_TIMEOUT_OFF, CORR_ERR_REPORT_ON, FATAL_ERR_REPORT_ON, TX_TURN_OFF;
  wire RELAXED_ORDER_ALLOWED, WIDE_TAG_ALLOWED, TX_PM_REQ_ACK, TX_ERR_COR;
  wire TX_TURN_OFF_ACK, TX_ERR_NONFATAL, TX_ERR_FATAL, RX_REQ_ACCEPT;
  wire [2:0] PAYLOAD_LIMIT, READ_REQUEST_LIMIT;
  wire [3:0] CPL_TIMEOUT_RANGE;
  wire [8:0] USER_FLAGS;
  wire [6:0] CFG_ACCESS_DWORD_OFFSET;
  wire [15:0] MSG_DATA;
  wire [31:0] PRDATA, USER_SIZES;
  cfgpm_top dut (.*);
  cfgpm_user_model user (.*);
  always #4 MCLK = !MCLK;
  // Compare, count, report at once
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      bad_count++;
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask
  // One-cycle pulse; returns while the registered answer stands
  task automatic pulse(input logic [15:0] v);
    @(posedge MCLK) ev <= v;
    @(posedge MCLK) ev <= 16'h0000;
    #1;
  endtask
  // APB master: request held until PREADY is seen at a rising edge
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
    int n = 0;
    @(posedge MCLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, a, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    rd = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset, reset-value checks and a first error case, table of accesses, then hand-written cases
  initial begin
    repeat (6) @(posedge MCLK);
    SYS_RST <= 1'b0;
    wt(1);
    chk({PREADY, PM_ACK_SEEN_N, BUS_MASTER_ALLOWED, MSG_DATA}, 32'h20000);
    chk(USER_FLAGS, 32'h0A2);
    chk(USER_SIZES, 32'h00800080);
    @(posedge MCLK) INTX_REQ <= 1'b1;
    pulse(16'h0780);
    chk({RX_REQ_ACCEPT, TX_UR, TX_INTX, TX_ERR_COR, TX_ERR_NONFATAL,
      TX_ERR_FATAL}, 32'h18);
    foreach (rows[i]) begin
      @(posedge MCLK) {RX_CFG_DWORD, RX_CFG_WRITE, RX_CFG_DATA} <= rows[i];
      pulse(16'h2000);
      chk(CFG_ACCESS_PULSE, rows[i][42:33] < 10'h080);
      if (rows[i][42:33] < 10'h080) begin
        chk({CFG_ACCESS_DWORD_OFFSET, CFG_ACCESS_IS_WRITE}, rows[i][39:32]);
      end
    end
    chk({IO_SPACE_ALLOWED, MEM_SPACE_ALLOWED, BUS_MASTER_ALLOWED,
      SYSTEM_ERROR_ALLOWED, LEGACY_IRQ_BLOCKED}, 32'h1F);
    chk({CORR_ERR_REPORT_ON, FATAL_ERR_REPORT_ON, RELAXED_ORDER_ALLOWED,
      WIDE_TAG_ALLOWED, PAYLOAD_LIMIT, READ_REQUEST_LIMIT}, 32'h2DD);
    chk({CPL_TIMEOUT_OFF, CPL_TIMEOUT_RANGE}, 32'h1E);
    chk(USER_FLAGS, 32'h11D);
    chk(USER_SIZES, 32'h04001000);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'hFFADD);
    @(posedge MCLK) INTX_REQ <= 1'b1;
    wt(2);
    chk(TX_INTX, 1'b0);
    pulse(16'h0700);
    chk({TX_ERR_COR, TX_ERR_NONFATAL, TX_ERR_FATAL}, 32'h7);
    pulse(16'h00C0);
    chk({RX_REQ_ACCEPT, TX_UR}, 32'h2);
    pulse(16'h0008);
    chk(PM_ACK_SEEN_N, 1'b0);
    @(posedge MCLK) RX_MSG_RID <= 16'hA5C3;
    pulse(16'h0010);
    chk({TURN_OFF_MSG_SEEN, MSG_DATA}, 32'h1A5C3);
    wt(2);
    chk(TX_TURN_OFF_ACK, 1'b1);
    pulse(16'h4000);
    chk(TX_PME, 1'b1);
    apb(1'b1, 12'h000, 32'h1);
    for (int m = 0; m < 2; m++) begin
      @(posedge MCLK) NAK_MODE <= m[0];
      pulse(16'h0004);
      chk(ASPM_L1_REQUEST_SEEN_N, 1'b0);
      wt(2);
      chk({TX_PM_REQ_ACK, TX_AS_NAK}, m[0] ? 32'h1 : 32'h2);
    end
    pulse(16'h0001);
    chk(TX_PM_REQ_ACK, 1'b1);
    pulse(16'h1900);
    chk({TX_ERR_COR, TX_ERR_NONFATAL, TX_ERR_FATAL}, 32'h3);
    pulse(16'h8000);
    chk(TX_TURN_OFF, 1'b1);
    pulse(16'h0020);
    chk(TURN_OFF_ACK_SEEN, 1'b1);
    pulse(16'h0002);
    chk({L23_ENTRY_SEEN_N, L3_READY}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h13);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== sim/cfgpm_user_model.sv
// User application model facing the sideband outputs of the block.
// Assumes the device's request pulses are registered on MCLK.
`timescale 1ns/100ps
`default_nettype none
module cfgpm_user_model (
  // Clock, reset, device outputs and the bench's NAK_MODE select
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic ASPM_L1_REQUEST_SEEN_N,
  input wire logic TURN_OFF_MSG_SEEN,
  input wire logic NAK_MODE,
  // Mirrors that bound what user logic may request
  input wire logic BUS_MASTER_ALLOWED,
  input wire logic IO_SPACE_ALLOWED,
  input wire logic MEM_SPACE_ALLOWED,
  input wire logic CPL_TIMEOUT_OFF,
  input wire logic RELAXED_ORDER_ALLOWED,
  input wire logic WIDE_TAG_ALLOWED,
  input wire logic [2:0] PAYLOAD_LIMIT,
  input wire logic [2:0] READ_REQUEST_LIMIT,
  // Replies to the device and the request policy user logic follows
  output logic PM_ACK_SEND_N,
  output logic PM_NAK_SEND_N,
  output logic POWER_OFF_SAFE_N,
  output logic [8:0] USER_FLAGS,
  output logic [31:0] USER_SIZES
);
  // Reply one cycle after a request; the power-off grant is held once given
  always_ff @(posedge MCLK) begin
    PM_ACK_SEND_N <= SYS_RST | ASPM_L1_REQUEST_SEEN_N;
    PM_NAK_SEND_N <= SYS_RST | ASPM_L1_REQUEST_SEEN_N | !NAK_MODE;
    POWER_OFF_SAFE_N <= SYS_RST
      | POWER_OFF_SAFE_N & !TURN_OFF_MSG_SEEN;
  end
  // Request policy read from the mirrors before any request is built
  assign USER_FLAGS = {WIDE_TAG_ALLOWED ? 4'h8 : 4'h5,
    BUS_MASTER_ALLOWED,
    IO_SPACE_ALLOWED, MEM_SPACE_ALLOWED,
    !CPL_TIMEOUT_OFF,
    RELAXED_ORDER_ALLOWED};
  // Size limits in bytes; each step of a limit field doubles the size
  assign USER_SIZES = {16'h0080 << PAYLOAD_LIMIT,
    16'h0080 << READ_REQUEST_LIMIT};
endmodule
`default_nettype wire
